// ### hdl/tba_defines.svh
`ifndef TBA_DEFINES_SVH
`define TBA_DEFINES_SVH

// pointer geometry
`define TBA_PTR_W 22
`define TBA_ADDR_W 21
`define TBA_CFG_BIT 21
`define TBA_UPPER_USED 6
`define TBA_WORD_W 16
`define TBA_BYTE_W 8

// special register indices on the core's register port
`define TBA_REG_LATCH 2'h0
`define TBA_REG_PTR_UPPER 2'h1
`define TBA_REG_PTR_HIGH 2'h2
`define TBA_REG_PTR_LOW 2'h3

// reset values
`define TBA_LATCH_RESET 8'h00
`define TBA_PTR_RESET 22'h000000

// timing: a table write holds for two instruction cycles
`define TBA_WRITE_CYCLES 2
`define TBA_READ_CYCLES 2

`endif

// ### hdl/tba_pkg.sv
package tba_pkg;

	// pointer update variant selected by the instruction argument
	typedef enum logic [1:0] {
		TBA_PTR_HOLD,
		TBA_PTR_POST_INC,
		TBA_PTR_POST_DEC,
		TBA_PTR_PRE_INC
	} tba_ptr_mode_e;

	// request from the instruction decoder
	typedef struct packed {
		logic read_op;
		logic write_op;
		tba_ptr_mode_e mode;
	} tba_cmd_s;

	// register port from the core
	typedef struct packed {
		logic wr;
		logic [1:0] sel;
		logic [7:0] wdata;
	} tba_reg_s;

	// external memory bus presentation
	typedef struct packed {
		logic wr_strobe;
		logic [21:0] addr;
		logic [7:0] data;
	} tba_ext_s;

endpackage

// ### hdl/tba_ptr_step.sv
`timescale 1ns/1ps
`include "tba_defines.svh"

// computes the next pointer; only the low address field moves
module tba_ptr_step (
	// current pointer and requested variant
	input wire logic [`TBA_PTR_W-1:0] ptr,
	input wire tba_pkg::tba_ptr_mode_e mode,
	// results
	output logic [`TBA_PTR_W-1:0] access_addr,
	output logic [`TBA_PTR_W-1:0] next_ptr
);
	logic [`TBA_ADDR_W-1:0] inc_addr;
	logic [`TBA_ADDR_W-1:0] dec_addr;

	// wraps inside the 21-bit field so no carry reaches the space select
	assign inc_addr = ptr[`TBA_ADDR_W-1:0] + `TBA_ADDR_W'(1);
	assign dec_addr = ptr[`TBA_ADDR_W-1:0] - `TBA_ADDR_W'(1);

	always_comb begin
		access_addr = ptr;
		next_ptr = ptr;
		case (mode)
			tba_pkg::TBA_PTR_HOLD: begin
				next_ptr = ptr;
			end
			tba_pkg::TBA_PTR_POST_INC: begin
				next_ptr = {ptr[`TBA_CFG_BIT], inc_addr};
			end
			tba_pkg::TBA_PTR_POST_DEC: begin
				next_ptr = {ptr[`TBA_CFG_BIT], dec_addr};
			end
			tba_pkg::TBA_PTR_PRE_INC: begin
				next_ptr = {ptr[`TBA_CFG_BIT], inc_addr};
				access_addr = next_ptr;
			end
			default: begin
				next_ptr = ptr;
			end
		endcase
	end
endmodule

// ### hdl/tba_table_access.sv
`timescale 1ns/1ps
`include "tba_defines.svh"

// Operation
// - each table read loads exactly one byte into the latch
// - an 8-bit software-visible latch holds every byte in transit
// - pointer is upper low six bits, high byte, low byte: 22 bits
// - low 21 pointer bits select a byte in program space
// - pointer bit 21 set selects configuration space
// - plain variant keeps pointer; pre-increment adds one then accesses
// - post variants access current byte, then add or subtract one
// - auto increment and decrement change only the low 21 bits
// - all 22 pointer bits choose the accessed byte
// - bridges 16-bit program space and 8-bit RAM through the latch
// - table write presents the data byte on the external data bus
// - without external bus, table write takes two cycles and only updates the pointer
// - executing an invalid program word performs a no-operation
// - data blocks may start anywhere; code must stay word aligned
// - on-chip program memory is never programmed or erased here
// - pointer bit 0 picks the low or high byte of the word
// - table write drives pointer on address bus, latch on data bus
module tba_table_access #(
	parameter bit HAS_EXT_BUS = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// instruction decoder
	input wire tba_pkg::tba_cmd_s cmd,
	input wire logic cmd_valid,
	output logic busy,
	output logic done,
	// instruction fetch validity check
	input wire logic fetch_valid,
	input wire logic fetch_decodes,
	output logic fetch_nop,
	// core register port
	input wire tba_pkg::tba_reg_s reg_in,
	input wire logic [1:0] reg_rsel,
	output logic [7:0] reg_rdata,
	// program memory word read port, same clock domain
	output logic [`TBA_PTR_W-2:0] mem_word_addr,
	output logic mem_cfg_sel,
	output logic mem_rd,
	input wire logic [`TBA_WORD_W-1:0] mem_rdata,
	// external memory bus
	output tba_pkg::tba_ext_s ext_bus
);
	typedef enum logic [1:0] {
		TBA_IDLE,
		TBA_READ,
		TBA_WRITE,
		TBA_FINISH
	} tba_state_e;

	tba_state_e state;
	logic [`TBA_BYTE_W-1:0] latch;
	logic [`TBA_UPPER_USED-1:0] ptr_upper;
	logic [`TBA_BYTE_W-1:0] ptr_high;
	logic [`TBA_BYTE_W-1:0] ptr_low;
	logic [`TBA_PTR_W-1:0] ptr;
	logic [`TBA_PTR_W-1:0] access_addr;
	logic [`TBA_PTR_W-1:0] next_ptr;
	logic [`TBA_PTR_W-1:0] op_addr;
	logic [`TBA_PTR_W-1:0] op_next_ptr;
	logic op_write;
	logic start;
	logic [`TBA_BYTE_W-1:0] picked_byte;

	assign ptr = {ptr_upper, ptr_high, ptr_low};
	assign start = cmd_valid && (state == TBA_IDLE)
		&& (cmd.read_op || cmd.write_op);
	assign busy = (state != TBA_IDLE);

	tba_ptr_step u_step (
		.ptr(ptr),
		.mode(cmd.mode),
		.access_addr(access_addr),
		.next_ptr(next_ptr)
	);

	// operation sequencing; every op spans two instruction cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= TBA_IDLE;
		end else begin
			case (state)
				TBA_IDLE: begin
					if (start && cmd.write_op) begin
						state <= TBA_WRITE;
					end else if (start) begin
						state <= TBA_READ;
					end
				end
				TBA_READ: begin
					state <= TBA_FINISH;
				end
				TBA_WRITE: begin
					state <= TBA_FINISH;
				end
				TBA_FINISH: begin
					state <= TBA_IDLE;
				end
				default: begin
					state <= TBA_IDLE;
				end
			endcase
		end
	end

	// operation address captured at start, full 22 bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_addr <= `TBA_PTR_RESET;
			op_next_ptr <= `TBA_PTR_RESET;
			op_write <= 1'b0;
		end else if (start) begin
			op_addr <= access_addr;
			op_next_ptr <= next_ptr;
			op_write <= cmd.write_op;
		end
	end

	// word fetch for reads; bit 21 routes to configuration space
	assign mem_word_addr = op_addr[`TBA_PTR_W-1:1];
	assign mem_cfg_sel = op_addr[`TBA_CFG_BIT];
	assign mem_rd = (state == TBA_READ);

	// only one byte of the 16-bit word ever reaches the latch
	assign picked_byte = op_addr[0] ? mem_rdata[15:8]
		: mem_rdata[7:0];

	// latch: software writes win only when no read completes that cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch <= `TBA_LATCH_RESET;
		end else if (state == TBA_READ) begin
			latch <= picked_byte;
		end else if (reg_in.wr && reg_in.sel == `TBA_REG_LATCH) begin
			latch <= reg_in.wdata;
		end
	end

	// pointer registers; hardware update commits at end of op
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{ptr_upper, ptr_high, ptr_low} <= `TBA_PTR_RESET;
		end else if (state == TBA_FINISH) begin
			{ptr_upper, ptr_high, ptr_low} <= op_next_ptr;
		end else if (reg_in.wr) begin
			case (reg_in.sel)
				`TBA_REG_PTR_UPPER: begin
					ptr_upper <= reg_in.wdata[`TBA_UPPER_USED-1:0];
				end
				`TBA_REG_PTR_HIGH: begin
					ptr_high <= reg_in.wdata;
				end
				`TBA_REG_PTR_LOW: begin
					ptr_low <= reg_in.wdata;
				end
				default: begin
					ptr_low <= ptr_low;
				end
			endcase
		end
	end

	// register readback; unused upper pointer bits read zero
	always_comb begin
		case (reg_rsel)
			`TBA_REG_LATCH: reg_rdata = latch;
			`TBA_REG_PTR_UPPER: reg_rdata = {2'h0, ptr_upper};
			`TBA_REG_PTR_HIGH: reg_rdata = ptr_high;
			`TBA_REG_PTR_LOW: reg_rdata = ptr_low;
			default: reg_rdata = 8'h00;
		endcase
	end

	// external bus: registered; on-chip array has no write path at all,
	// so a write can never program or erase it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_bus <= '0;
		end else if (HAS_EXT_BUS && state == TBA_WRITE) begin
			ext_bus.wr_strobe <= 1'b1;
			ext_bus.addr <= op_addr;
			ext_bus.data <= latch;
		end else begin
			ext_bus.wr_strobe <= 1'b0;
		end
	end

	// completion pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
		end else begin
			done <= (state == TBA_FINISH);
		end
	end

	// an undecodable fetched word executes as a no-operation
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_nop <= 1'b0;
		end else begin
			fetch_nop <= fetch_valid && !fetch_decodes;
		end
	end

	logic unused_ok;
	assign unused_ok = op_write;
endmodule

// ### verification/tba_prog_mem.sv
`timescale 1ns/1ps
// read-only array: there is no write path at all
module tba_prog_mem (
	// word read port
	input wire logic clk,
	input wire logic [20:0] word_addr,
	input wire logic cfg_sel,
	input wire logic rd,
	output logic [15:0] rdata
);
	logic [15:0] w;
	assign w = {~word_addr[7:0], word_addr[7:0] ^ {cfg_sel, 7'h00}};
	// idle port moves every cycle so a late sample cannot pass by luck
	assign rdata = rd ? w : ~w ^ {16{clk}};
endmodule

// ### verification/tba_table_access_bench.sv
`timescale 1ns/1ps
module tba_table_access_bench;
	typedef struct packed {
		logic w;
		logic [1:0] m;
		logic [21:0] p;
		logic [21:0] q;
	} tba_row_s;
	logic clk = 0, rst_n = 0, cmd_valid = 0, busy, done, done0;
	logic fetch_valid = 0, fetch_decodes = 0, fetch_nop, mem_cfg_sel, mem_rd;
	tba_pkg::tba_cmd_s cmd = '0;
	tba_pkg::tba_reg_s reg_in = '0;
	tba_pkg::tba_ext_s ext_bus, ext_bus0, sb;
	logic [1:0] reg_rsel = 0;
	logic [7:0] reg_rdata, d;
	logic [20:0] mem_word_addr;
	logic [15:0] mem_rdata;
	logic [21:0] a;
	int mismatches = 0, n_checks = 0;
	tba_row_s rows[8] = '{'{1'h0, 2'h0, 22'h0, 22'h0},
		'{1'h0, 2'h1, 22'h1, 22'h2}, '{1'h0, 2'h1, 22'h1fffff, 22'h0},
		'{1'h0, 2'h2, 22'h200000, 22'h3fffff},
		'{1'h0, 2'h3, 22'hff, 22'h100}, '{1'h0, 2'h3, 22'h3ffffe, 22'h3fffff},
		'{1'h1, 2'h0, 22'h12345, 22'h12345},
		'{1'h1, 2'h2, 22'h200001, 22'h200000}};
	always #10 clk = ~clk;
	tba_table_access #(.HAS_EXT_BUS(1'b1)) dut (.clk(clk), .rst_n(rst_n),
		.cmd(cmd), .cmd_valid(cmd_valid), .busy(busy), .done(done),
		.fetch_valid(fetch_valid), .fetch_decodes(fetch_decodes),
		.fetch_nop(fetch_nop), .reg_in(reg_in), .reg_rsel(reg_rsel),
		.reg_rdata(reg_rdata), .mem_word_addr(mem_word_addr),
		.mem_cfg_sel(mem_cfg_sel), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
		.ext_bus(ext_bus));
	// part without the external bus: a write must leave that bus quiet
	tba_table_access #(.HAS_EXT_BUS(1'b0)) dut_nobus (.clk(clk),
		.rst_n(rst_n), .cmd(cmd), .cmd_valid(cmd_valid), .busy(),
		.done(done0), .fetch_valid(fetch_valid),
		.fetch_decodes(fetch_decodes), .fetch_nop(), .reg_in(reg_in),
		.reg_rsel(reg_rsel), .reg_rdata(), .mem_word_addr(),
		.mem_cfg_sel(), .mem_rd(), .mem_rdata(mem_rdata),
		.ext_bus(ext_bus0));
	tba_prog_mem mem (.clk(clk), .word_addr(mem_word_addr),
		.cfg_sel(mem_cfg_sel), .rd(mem_rd), .rdata(mem_rdata));
	task chk(input logic [30:0] s, input logic [30:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wreg(input logic [1:0] s, input logic [7:0] v);
		@(posedge clk) reg_in <= '{1'b1, s, v};
		@(posedge clk) reg_in.wr <= 0;
	endtask
	task ptr(input logic [21:0] e);
		logic [23:0] v;
		for (int k = 1; k < 4; k++) begin
			@(posedge clk) reg_rsel <= k[1:0];
			#1 v = {v[15:0], reg_rdata};
		end
		chk(v[21:0], e);
	endtask
	// holding the request a second cycle also checks it is ignored while busy
	task op(input logic w, input logic [1:0] m);
		@(posedge clk) cmd <= '{!w, w, tba_pkg::tba_ptr_mode_e'(m)};
		cmd_valid <= 1;
		repeat (2) @(posedge clk);
		cmd_valid <= 0;
		repeat (6) begin
			#1 if (ext_bus.wr_strobe === 1) sb = ext_bus;
			if (done === 1) break;
			@(posedge clk);
		end
		chk(done, 1);
		chk(done0, 1);
		chk(ext_bus0, 0);
	endtask
	initial begin
		#100000 mismatches++;
		summarize;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) reg_rsel <= i[1:0];
			#1 chk(reg_rdata, 0);
		end
		foreach (rows[j]) begin
			a = rows[j].m == 2'h3 ? rows[j].q : rows[j].p;
			d = 8'h5a ^ j[7:0];
			wreg(0, d);
			wreg(1, {2'h3, rows[j].p[21:16]});
			wreg(2, rows[j].p[15:8]);
			wreg(3, rows[j].p[7:0]);
			sb = '0;
			op(rows[j].w, rows[j].m);
			ptr(rows[j].q);
			@(posedge clk) reg_rsel <= 0;
			#1 if (rows[j].w)
				chk(sb, {1'b1, a, d});
			else
				chk(reg_rdata, 8'(a[0] ? ~a[8:1]
					: a[8:1] ^ {a[21], 7'h0}));
		end
		@(posedge clk) fetch_valid <= 1;
		@(posedge clk) fetch_decodes <= 1;
		#1 chk(fetch_nop, 1);
		@(posedge clk) fetch_valid <= 0;
		#1 chk(fetch_nop, 0);
		// reset in the middle of a write: nothing of it may survive
		@(posedge clk) cmd <= '{1'b0, 1'b1, tba_pkg::TBA_PTR_POST_INC};
		cmd_valid <= 1;
		@(posedge clk) cmd_valid <= 0;
		@(posedge clk) rst_n <= 0;
		#1 chk({busy, done}, 0);
		chk(ext_bus, 0);
		repeat (2) @(posedge clk);
		rst_n <= 1;
		ptr(0);
		@(posedge clk) reg_rsel <= 0;
		#1 chk(reg_rdata, 0);
		summarize;
	end
endmodule

// ### verification/tba_table_access_monitor.sv
`timescale 1ns/1ps
module tba_table_access_monitor #(
	parameter bit HAS_EXT_BUS = 1'b1
) (
	// clock, reset, decoder
	input wire logic clk,
	input wire logic rst_n,
	input wire tba_pkg::tba_cmd_s cmd,
	input wire logic cmd_valid,
	input wire logic busy,
	input wire logic done,
	// fetch and registers
	input wire logic fetch_valid,
	input wire logic fetch_decodes,
	input wire logic fetch_nop,
	input wire tba_pkg::tba_reg_s reg_in,
	input wire logic [1:0] reg_rsel,
	input wire logic [7:0] reg_rdata,
	// memory sides
	input wire logic [20:0] mem_word_addr,
	input wire logic mem_cfg_sel,
	input wire logic mem_rd,
	input wire logic [15:0] mem_rdata,
	input wire tba_pkg::tba_ext_s ext_bus
);
	logic tk;
	assign tk = cmd_valid && !busy && (cmd.read_op || cmd.write_op);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_done_three: assert property (tk |-> ##3 done)
		else $error("done not three cycles after start");
	a_busy_span: assert property (tk |=> busy [*2])
		else $error("busy dropped early");
	a_read_fetch: assert property (tk && !cmd.write_op |=> mem_rd ##1 !mem_rd)
		else $error("read fetch not a single cycle");
	a_write_strobe: assert property (tk && cmd.write_op
		|-> ##2 ext_bus.wr_strobe == HAS_EXT_BUS)
		else $error("write strobe missing or stray");
	a_write_no_rd: assert property (tk && cmd.write_op |=> !mem_rd [*3])
		else $error("write touched the program array");
	a_upper_six: assert property (reg_rsel == 2'h1
		|-> reg_rdata[7:6] == 2'h0)
		else $error("unused upper pointer bits read back");
	a_fetch_nop: assert property (fetch_valid && !fetch_decodes
		|=> fetch_nop)
		else $error("invalid word did not give a nop");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
endmodule
bind tba_table_access tba_table_access_monitor #(.HAS_EXT_BUS(HAS_EXT_BUS))
	u_mon (.clk(clk), .rst_n(rst_n), .cmd(cmd), .cmd_valid(cmd_valid),
	.busy(busy), .done(done), .fetch_valid(fetch_valid),
	.fetch_decodes(fetch_decodes), .fetch_nop(fetch_nop), .reg_in(reg_in),
	.reg_rsel(reg_rsel), .reg_rdata(reg_rdata), .mem_rd(mem_rd),
	.mem_word_addr(mem_word_addr), .mem_cfg_sel(mem_cfg_sel),
	.mem_rdata(mem_rdata), .ext_bus(ext_bus));
